// [verilog/pcr_map.svh]
// constants for the port configuration and pin remap block
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH
`define PCR_NPIN        26
`define PCR_NFN         8
// write addresses
`define PCR_A_LATCH     4'h0
`define PCR_A_CFG1      4'h4
`define PCR_A_CFG2      4'h8
`define PCR_A_DIS       4'hc
`define PCR_A_REMAP     4'hd
// write masks
`define PCR_PORT3_MASK  8'h03
`define PCR_DIS_MASK    8'h3e
`define PCR_REMAP_MASK  8'h07
// reset values
`define PCR_RST_LATCH   32'hffffffff
`define PCR_RST_CFG1    32'hffffffff
`define PCR_RST_CFG2    32'h00000000
`define PCR_RST_DIS     8'h00
`define PCR_RST_REMAP   8'h00
// remap control bits
`define PCR_RM_UART     0
`define PCR_RM_I2C      1
`define PCR_RM_SPI      2
// special pins, flat index = port*8+bit
`define PCR_P12         5'd10
`define PCR_P13         5'd11
`define PCR_P15         5'd13
// function index order: clk mosi miso ss sda scl txd rxd
`define PCR_FN_PRI      {5'd9, 5'd8, 5'd10, 5'd11, 5'd20, 5'd19, 5'd18, 5'd21}
`define PCR_FN_ALT      {5'd17, 5'd16, 5'd22, 5'd23, 5'd12, 5'd14, 5'd15, 5'd0}
// usable pin count and clock source codes
`define PCR_IO_MAX      5'd26
`define PCR_CLK_RC      2'h0
`define PCR_CLK_EXT     2'h1
`endif

// [verilog/pcr_pkg.sv]
// types for the port configuration and pin remap block
package pcr_pkg;
  // pin mode code {cfg1,cfg2}
  typedef enum logic [1:0] {
    PCR_QUASI = 2'h0,
    PCR_PUSH  = 2'h1,
    PCR_INPUT = 2'h2,
    PCR_OPEN  = 2'h3
  } pcr_mode_t;

  typedef struct packed {
    logic [25:0] out;
    logic [25:0] oe;
    logic [25:0] weak_pu;
  } pcr_drive_t;

  typedef struct packed {
    logic [31:0] latch;
    logic [31:0] cfg1;
    logic [31:0] cfg2;
    logic [7:0]  dis;
    logic [7:0]  remap;
    pcr_drive_t  drv;
    logic [25:0] rd;
    logic [7:0]  fn_in;
    logic        ext_rst_n;
    logic [4:0]  io_count;
  } pcr_state_t;
endpackage

// [verilog/pcr_port_remap.sv]
// gpio port configuration, digital input disable and serial pin remap
`timescale 1ns/1ns
`include "pcr_map.svh"

// Behaviour
// - ports 0..2 eight bits, port 3 two
// - each pin picks one of four modes
// - two config registers per port choose mode
// - P1.5 always input only
// - P1.2, P1.3 input-only or open-drain only
// - quasi: weak high, strong low
// - open-drain: pull-down only on latch zero
// - input-only: all drivers off
// - push-pull: strong high on latch one
// - port0 bits 1-5 input disable, reset clears
// - reset puts every pin input-only
// - per-peripheral remap via remap control
// - reset selects primary pin sets
// - fixed primary and alternative pin table
// - usable pin count from clock/reset options
// - reset enable makes P1.5 reset input
module pcr_port_remap (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              cfg_wr,
  input  wire logic [3:0]        cfg_addr,
  input  wire logic [7:0]        cfg_wdata,
  input  wire logic              reset_pin_enable,
  input  wire logic [1:0]        clk_src,
  input  wire logic [25:0]       pin_in,
  input  wire logic [7:0]        fn_out,
  output pcr_pkg::pcr_drive_t    pin_drv,
  output logic      [25:0]       pin_rd,
  output logic      [7:0]        fn_in,
  output logic                   ext_rst_n,
  output logic      [4:0]        io_count,
  output logic      [7:0]        port0_digital_input_disable,
  output logic      [7:0]        pin_remap_control
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic pcr_pkg::pcr_mode_t eff_mode(input logic [4:0] p, input logic c1, input logic c2);
    pcr_pkg::pcr_mode_t m;
    m = pcr_pkg::pcr_mode_t'({c1, c2});
    if (p == `PCR_P15) begin
      m = pcr_pkg::PCR_INPUT;
    end else if ((p == `PCR_P12) || (p == `PCR_P13)) begin
      if (m != pcr_pkg::PCR_OPEN) begin
        m = pcr_pkg::PCR_INPUT;
      end
    end
    return m;
  endfunction

  function automatic logic [4:0] fn_pin(input logic [2:0] f, input logic [7:0] rm);
    logic [39:0] pri;
    logic [39:0] alt;
    logic        use_alt;
    pri = `PCR_FN_PRI;
    alt = `PCR_FN_ALT;
    // spi 0..3, i2c 4..5, uart 6..7
    if (f < 3'd4) begin
      use_alt = rm[`PCR_RM_SPI];
    end else if (f < 3'd6) begin
      use_alt = rm[`PCR_RM_I2C];
    end else begin
      use_alt = rm[`PCR_RM_UART];
    end
    return use_alt ? alt[5*f +: 5] : pri[5*f +: 5];
  endfunction

  function automatic logic [7:0] port_byte(input logic [1:0] port, input logic [7:0] data);
    logic [7:0] mask;
    mask = (port == 2'h3) ? `PCR_PORT3_MASK : 8'hff;
    return data & mask;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  pcr_pkg::pcr_state_t r_reg;
  pcr_pkg::pcr_state_t r_next;

  always_comb begin
    logic                d;
    logic [4:0]          p;
    logic [4:0]          cnt;
    pcr_pkg::pcr_mode_t  m;
    d      = 1'b0;
    p      = 5'd0;
    cnt    = `PCR_IO_MAX;
    m      = pcr_pkg::PCR_INPUT;
    r_next = r_reg;

    // ************************************************************
    // software writes, port 3 keeps two bits
    // ************************************************************
    if (cfg_wr) begin
      case (cfg_addr[3:2])
        2'h0: begin
          r_next.latch[8*cfg_addr[1:0] +: 8] = port_byte(cfg_addr[1:0], cfg_wdata);
        end
        2'h1: begin
          r_next.cfg1[8*cfg_addr[1:0] +: 8] = port_byte(cfg_addr[1:0], cfg_wdata);
        end
        2'h2: begin
          r_next.cfg2[8*cfg_addr[1:0] +: 8] = port_byte(cfg_addr[1:0], cfg_wdata);
        end
        default: begin
          if (cfg_addr == `PCR_A_DIS) begin
            r_next.dis = cfg_wdata & `PCR_DIS_MASK;
          end else if (cfg_addr == `PCR_A_REMAP) begin
            r_next.remap = cfg_wdata & `PCR_REMAP_MASK;
          end
        end
      endcase
    end

    // ************************************************************
    // pin drivers from current settings
    // ************************************************************
    for (int i = 0; i < `PCR_NPIN; i++) begin
      p = 5'(i);
      d = r_reg.latch[i];
      // a mapped peripheral can only pull its pin low
      for (int f = 0; f < `PCR_NFN; f++) begin
        if (fn_pin(3'(f), r_reg.remap) == p) begin
          d = d & fn_out[f];
        end
      end
      m = eff_mode(p, r_reg.cfg1[i], r_reg.cfg2[i]);
      // strong drive through oe, weak pull-up apart
      case (m)
        pcr_pkg::PCR_QUASI: begin
          r_next.drv.out[i]     = 1'b0;
          r_next.drv.oe[i]      = ~d;
          r_next.drv.weak_pu[i] = d;
        end
        pcr_pkg::PCR_PUSH: begin
          r_next.drv.out[i]     = d;
          r_next.drv.oe[i]      = 1'b1;
          r_next.drv.weak_pu[i] = 1'b0;
        end
        pcr_pkg::PCR_OPEN: begin
          r_next.drv.out[i]     = 1'b0;
          r_next.drv.oe[i]      = ~d;
          r_next.drv.weak_pu[i] = 1'b0;
        end
        default: begin
          r_next.drv.out[i]     = 1'b0;
          r_next.drv.oe[i]      = 1'b0;
          r_next.drv.weak_pu[i] = 1'b0;
        end
      endcase
    end

    // ************************************************************
    // pin reads, disabled analog inputs read zero
    // ************************************************************
    r_next.rd = pin_in & ~{18'h0, r_reg.dis};

    // ************************************************************
    // peripheral inputs follow the remap
    // ************************************************************
    for (int f = 0; f < `PCR_NFN; f++) begin
      r_next.fn_in[f] = pin_in[fn_pin(3'(f), r_reg.remap)];
    end

    // ************************************************************
    // reset pin
    // ************************************************************
    r_next.ext_rst_n = reset_pin_enable ? pin_in[`PCR_P15] : 1'b1;

    // ************************************************************
    // clock pins and reset pin take away usable io
    // ************************************************************
    if (clk_src == `PCR_CLK_EXT) begin
      cnt = cnt - 5'd1;
    end else if (clk_src != `PCR_CLK_RC) begin
      cnt = cnt - 5'd2;
    end
    if (reset_pin_enable) begin
      cnt = cnt - 5'd1;
    end
    r_next.io_count = cnt;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // every pin input-only, primary pin map
      r_reg.latch     <= `PCR_RST_LATCH;
      r_reg.cfg1      <= `PCR_RST_CFG1;
      r_reg.cfg2      <= `PCR_RST_CFG2;
      r_reg.dis       <= `PCR_RST_DIS;
      r_reg.remap     <= `PCR_RST_REMAP;
      r_reg.drv       <= '0;
      r_reg.rd        <= '0;
      r_reg.fn_in     <= '0;
      r_reg.ext_rst_n <= 1'b1;
      r_reg.io_count  <= `PCR_IO_MAX;
    end else begin
      r_reg <= r_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign pin_drv                     = r_reg.drv;
  assign pin_rd                      = r_reg.rd;
  assign fn_in                       = r_reg.fn_in;
  assign ext_rst_n                   = r_reg.ext_rst_n;
  assign io_count                    = r_reg.io_count;
  assign port0_digital_input_disable = r_reg.dis;
  assign pin_remap_control           = r_reg.remap;

endmodule

// [test/pcr_props.sv]
// property checker for the port configuration and pin remap block
`timescale 1ns/1ns
module pcr_props (
  input logic               clk,
  input logic               rstn,
  input logic               cfg_wr,
  input logic [3:0]         cfg_addr,
  input logic [7:0]         cfg_wdata,
  input logic               reset_pin_enable,
  input logic [1:0]         clk_src,
  input logic [25:0]        pin_in,
  input pcr_pkg::pcr_drive_t pin_drv,
  input logic [25:0]        pin_rd,
  input logic               ext_rst_n,
  input logic [4:0]         io_count,
  input logic [7:0]         port0_digital_input_disable,
  input logic [7:0]         pin_remap_control
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_dis_wr; cfg_wr && cfg_addr == 4'hc; endsequence
  sequence s_map_wr; cfg_wr && cfg_addr == 4'hd; endsequence
  AST_P15_OFF: assert property (!pin_drv.oe[13] && !pin_drv.weak_pu[13]) else $error("p15 driven");
  AST_I2C_NO_HIGH: assert property ((pin_drv.oe[11:10] & pin_drv.out[11:10]) == 2'h0 &&
    pin_drv.weak_pu[11:10] == 2'h0) else $error("p12 p13 driven high");
  AST_DIS_WR: assert property (s_dis_wr |=> port0_digital_input_disable == ($past(cfg_wdata) & 8'h3e))
    else $error("disable write");
  AST_DIS_MASK: assert property ((port0_digital_input_disable & 8'hc1) == 8'h00) else $error("disable mask");
  AST_MAP_WR: assert property (s_map_wr |=> pin_remap_control == ($past(cfg_wdata) & 8'h07))
    else $error("remap write");
  AST_MAP_HOLD: assert property (!cfg_wr |=> $stable(pin_remap_control)) else $error("remap moved");
  AST_RD: assert property ($past(rstn) |-> pin_rd == ($past(pin_in) & ~{18'h0, $past(port0_digital_input_disable)}))
    else $error("pin read");
  AST_EXT_RST: assert property ($past(rstn) |-> ext_rst_n == ($past(reset_pin_enable) ? $past(pin_in[13]) : 1'b1))
    else $error("reset pin");
  AST_IO_CNT: assert property ($past(rstn) |-> io_count == 5'h1a - {4'h0, $past(reset_pin_enable)} -
    ($past(clk_src) == 2'h1 ? 5'h1 : $past(clk_src) > 2'h1 ? 5'h2 : 5'h0)) else $error("io count");
endmodule

// [test/pcr_board.sv]
// board model resolving pin levels
`timescale 1ns/1ns
module pcr_board (
  input  pcr_pkg::pcr_drive_t pin_drv,
  input  logic [25:0]         ext_oe,
  input  logic [25:0]         ext_val,
  output logic [25:0]         pin_in
);
  // device strong drive wins, board beats weak pull-up
  always_comb begin
    for (int i = 0; i < 26; i++) begin
      pin_in[i] = 1'b1;
      if (ext_oe[i])
        pin_in[i] = ext_val[i];
      if (pin_drv.oe[i])
        pin_in[i] = pin_drv.out[i];
    end
  end
endmodule

// [test/test_pcr_port_remap.sv]
// testbench for the port configuration and pin remap block
`timescale 1ns/1ns
module test_pcr_port_remap;
  logic                clk, rstn = 1'b0, cfg_wr = 1'b0, reset_pin_enable = 1'b0, ext_rst_n;
  logic [3:0]          cfg_addr = 4'h0;
  logic [7:0]          cfg_wdata = 8'h0, fn_out = 8'hff, fn_in, dis, remap;
  logic [1:0]          clk_src = 2'h0;
  logic [4:0]          io_count;
  logic [25:0]         pin_in, pin_rd, ext_oe = '0, ext_val = '0;
  pcr_pkg::pcr_drive_t pin_drv;
  int                  err_total = 0, checks = 0, cyc = 0;
  // pin index per function, function 0 in the low five bits
  localparam logic [39:0] PRI = {5'd9, 5'd8, 5'd10, 5'd11, 5'd20, 5'd19, 5'd18, 5'd21};
  localparam logic [39:0] ALT = {5'd17, 5'd16, 5'd22, 5'd23, 5'd12, 5'd14, 5'd15, 5'd0};
  pcr_port_remap uut (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .reset_pin_enable(reset_pin_enable), .clk_src(clk_src), .pin_in(pin_in), .fn_out(fn_out), .pin_drv(pin_drv),
    .pin_rd(pin_rd), .fn_in(fn_in), .ext_rst_n(ext_rst_n), .io_count(io_count),
    .port0_digital_input_disable(dis), .pin_remap_control(remap));
  pcr_board board (.pin_drv(pin_drv), .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk);
  endtask
  task automatic idle(input int n);
    cfg_wr = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // all four codes on port 2, then pull the quasi pin low from outside
  task automatic t_modes;
    wr(4'h2, 8'ha5);
    wr(4'h6, 8'h0f);
    wr(4'ha, 8'h33);
    idle(3);
    chk("p2 oe", 8'h72, pin_drv.oe[23:16]);
    chk("p2 out", 8'h20, pin_drv.out[23:16]);
    chk("p2 weak", 8'h80, pin_drv.weak_pu[23:16]);
    ext_oe = 26'h0800000;
    idle(3);
    chk("p2 rd", 8'h2d, pin_rd[23:16]);
    ext_oe = '0;
    $display("t_modes done");
  endtask
  task automatic t_special;
    wr(4'h1, 8'hff);
    wr(4'h5, 8'h00);
    wr(4'h9, 8'h00);
    idle(3);
    chk("p1 weak", 8'hd3, pin_drv.weak_pu[15:8]);
    chk("p1 oe", 8'h00, pin_drv.oe[15:8]);
    wr(4'h1, 8'h00);
    wr(4'h5, 8'hff);
    wr(4'h9, 8'hff);
    idle(3);
    chk("p1 od", 8'hdf, pin_drv.oe[15:8]);
    $display("t_special done");
  endtask
  task automatic t_disable;
    wr(4'h4, 8'hff);
    wr(4'hc, 8'hff);
    idle(3);
    chk("dis", 8'h3e, dis);
    chk("p0 rd", 8'hc1, pin_rd[7:0]);
    rstn = 1'b0;
    idle(2);
    rstn = 1'b1;
    idle(3);
    chk("dis rst", 8'h00, dis);
    chk("remap rst", 8'h00, remap);
    chk("oe rst", 8'h00, pin_drv.oe[15:8]);
    chk("p0 rd rst", 8'hff, pin_rd[7:0]);
    $display("t_disable done");
  endtask
  task automatic t_remap;
    logic [7:0] e0, e1, e2;
    ext_oe = '1;
    ext_val = 26'h2a5c3f0;
    for (int i = 0; i < 8; i++) begin
      e0[i] = ext_val[PRI[5*i +: 5]];
      e1[i] = ext_val[ALT[5*i +: 5]];
      e2[i] = (i == 4 || i == 5) ? ext_val[ALT[5*i +: 5]] : ext_val[PRI[5*i +: 5]];
    end
    idle(3);
    chk("fn pri", e0, fn_in);
    wr(4'hd, 8'hff);
    idle(3);
    chk("remap", 8'h07, remap);
    chk("fn alt", e1, fn_in);
    wr(4'hd, 8'h02);
    idle(3);
    chk("fn i2c alt", e2, fn_in);
    // txd held low by the uart, P1.0 and P2.0 push-pull
    fn_out = 8'hbf;
    wr(4'h5, 8'hfe);
    wr(4'h9, 8'h01);
    wr(4'h6, 8'hfe);
    wr(4'ha, 8'h01);
    idle(2);
    chk("txd pri", 8'h02, {6'h0, pin_drv.out[16], pin_drv.out[8]});
    wr(4'hd, 8'h01);
    idle(2);
    chk("txd alt", 8'h01, {6'h0, pin_drv.out[16], pin_drv.out[8]});
    fn_out = 8'hff;
    $display("t_remap done");
  endtask
  task automatic t_count;
    logic [7:0] e;
    ext_val = '0;
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 2; r++) begin
        clk_src = 2'(s);
        reset_pin_enable = 1'(r);
        idle(2);
        e = 8'h1a - 8'(r) - (s == 1 ? 8'h01 : s > 1 ? 8'h02 : 8'h00);
        chk("io", e, {3'h0, io_count});
        chk("rst pin", 8'(r == 0), {7'h0, ext_rst_n});
      end
    end
    $display("t_count done");
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      conclude;
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    idle(2);
    chk("oe init", 8'h00, pin_drv.oe[23:16] | pin_drv.weak_pu[23:16]);
    t_modes;
    t_special;
    t_disable;
    t_remap;
    t_count;
    conclude;
  end
endmodule
bind pcr_port_remap pcr_props chk (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .reset_pin_enable(reset_pin_enable), .clk_src(clk_src), .pin_in(pin_in),
  .pin_drv(pin_drv), .pin_rd(pin_rd), .ext_rst_n(ext_rst_n), .io_count(io_count),
  .port0_digital_input_disable(port0_digital_input_disable), .pin_remap_control(pin_remap_control));
